// ===== verilog/mcsfr_core_regs.sv
// Core special function registers and general-purpose register banks
//
// Operation
// (R1) Registers in upper 128 bytes, direct only
// (R2) Core registers live in the register area
// (R3) Bit 7 carry, set by arithmetic
// (R4) Bit 6 half carry, add only
// (R5) Bit 2 overflow, set by arithmetic
// (R6) Bit 0 keeps accumulator parity even
// (R7) Bits 5 and 1 software-only flags
// (R8) Bits 4:3 select active bank
// (R9) Four banks of eight bytes, low RAM
// (R10) Control bit 7 doubles baud, resets 0
// (R11) Control bits 6:0 reserved, kept clear
// (R12) Pointer bytes at 0x82/0x83, reset 0
// (R13) 16-bit pointer is high:low concatenation
// (R14) Stack pointer eight bits, resets to 7
// (R15) Software keeps configuration bit 7 set
// (R16) Configuration bit 6 selects rich serial
// (R17) Configuration bit 5 selects SPI over I2C
// (R18) Configuration bit 4 enables carrier on mask
// (R19) Either of bits 1:0 enables extended moves
`timescale 1ns/1ps
`default_nettype none
`include "mcsfr_defines.svh"
module mcsfr_core_regs (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Direct-address access from the core
  input  wire logic                 dir_wr,
  input  wire logic                 dir_rd,
  input  wire logic [7:0]           dir_addr,
  input  wire mcsfr_pkg::mcsfr_byte_t dir_wdata,
  output mcsfr_pkg::mcsfr_byte_t    dir_rdata,
  output logic                      dir_hit,
  // Indirect flag from the core; such accesses never reach these registers
  input  wire logic                 dir_indirect,
  // Register bank access by register number
  input  wire logic                 bank_wr,
  input  wire logic [2:0]           bank_reg,
  input  wire mcsfr_pkg::mcsfr_byte_t bank_wdata,
  output mcsfr_pkg::mcsfr_byte_t    bank_rdata,
  // Arithmetic flag updates from the execution unit
  input  wire mcsfr_pkg::mcsfr_alu_t alu_kind,
  input  wire logic                 alu_carry,
  input  wire logic                 alu_half,
  input  wire logic                 alu_ovf,
  // Accumulator, stack and pointer updates from the execution unit
  input  wire logic                 acc_load,
  input  wire mcsfr_pkg::mcsfr_byte_t acc_value,
  input  wire logic                 sp_load,
  input  wire mcsfr_pkg::mcsfr_byte_t sp_value,
  input  wire logic                 pointer_pair_word_load,
  input  wire mcsfr_pkg::mcsfr_word_t pointer_pair_word_value,
  // Views for the core and peripherals
  output mcsfr_pkg::mcsfr_byte_t    acc_out,
  output mcsfr_pkg::mcsfr_byte_t    aux_out,
  output mcsfr_pkg::mcsfr_byte_t    sp_out,
  output mcsfr_pkg::mcsfr_word_t    pointer_pair_word_out,
  output mcsfr_pkg::mcsfr_bank_t    bank_sel,
  output logic                      carry_flag,
  output logic                      baud_doubler,
  output logic                      rich_serial_enable,
  output logic                      sync_port_choice,
  output logic                      carrier_enable,
  output mcsfr_pkg::mcsfr_byte_t    carrier_pin_mask,
  output logic                      ext_move_enable
);
  import mcsfr_pkg::*;

  mcsfr_byte_t acc_q, acc_d;
  mcsfr_byte_t aux_q, aux_d;
  mcsfr_byte_t psw_q, psw_d;
  mcsfr_byte_t program_control_reg_q, program_control_reg_d;
  mcsfr_byte_t dpl_q, dpl_d;
  mcsfr_byte_t dph_q, dph_d;
  mcsfr_byte_t sp_q, sp_d;
  mcsfr_byte_t cfg_q, cfg_d;
  mcsfr_byte_t ext_pin_config_reg_q, ext_pin_config_reg_d;
  mcsfr_byte_t rdata_q, rdata_d;
  logic        hit_q, hit_d;

  // Only direct accesses in the upper half reach the register area
  wire upper_half = dir_addr >= `MCSFR_DIRECT_BASE;
  wire dir_ok     = upper_half && !dir_indirect; // R1
  wire wr_ok      = dir_wr && dir_ok;

  wire sel_acc   = dir_addr == `MCSFR_OFF_ACC;
  wire sel_b     = dir_addr == `MCSFR_OFF_B;
  wire sel_psw   = dir_addr == `MCSFR_OFF_PSW;
  wire sel_program_control_reg  = dir_addr == `MCSFR_OFF_PROGRAM_CONTROL_REG;
  wire sel_dpl   = dir_addr == `MCSFR_OFF_DPL;
  wire sel_dph   = dir_addr == `MCSFR_OFF_DPH;
  wire sel_sp    = dir_addr == `MCSFR_OFF_SP;
  wire sel_cfg   = dir_addr == `MCSFR_OFF_CFG;
  wire sel_ext_pin_config_reg = dir_addr == `MCSFR_OFF_EXT_PIN_CONFIG_REG;
  wire mapped    = sel_acc | sel_b | sel_psw | sel_program_control_reg | sel_dpl | sel_dph
                 | sel_sp | sel_cfg | sel_ext_pin_config_reg; // R2

  // Accumulator value after this cycle, used for parity
  wire mcsfr_byte_t acc_next = (wr_ok && sel_acc) ? dir_wdata
                             : acc_load ? acc_value : acc_q;

  wire arith    = alu_kind != MCSFR_ALU_NONE;
  wire add_kind = alu_kind == MCSFR_ALU_ADD;

  always_comb begin
    acc_d = acc_next;
    aux_d = (wr_ok && sel_b) ? dir_wdata : aux_q;
    psw_d = (wr_ok && sel_psw) ? dir_wdata : psw_q;
    // Hardware flag updates win over a software write in the same cycle
    if (arith) begin
      psw_d[`MCSFR_PSW_CY] = alu_carry; // R3
      psw_d[`MCSFR_PSW_OV] = alu_ovf; // R5
    end
    if (add_kind) begin
      psw_d[`MCSFR_PSW_AC] = alu_half; // R4
    end
    // F0/F1 and bank select change only via software write above
    psw_d[`MCSFR_PSW_P] = ^acc_next; // R6 R7
    // Reserved control bits read back zero
    program_control_reg_d = (wr_ok && sel_program_control_reg) ? (dir_wdata & `MCSFR_PROGRAM_CONTROL_REG_MASK) : program_control_reg_q; // R10 R11
    // A direct byte write wins over a word load in the same cycle
    dpl_d  = pointer_pair_word_load ? pointer_pair_word_value[7:0] : dpl_q;
    dph_d  = pointer_pair_word_load ? pointer_pair_word_value[15:8] : dph_q;
    if (wr_ok && sel_dpl) begin
      dpl_d = dir_wdata; // R12
    end
    if (wr_ok && sel_dph) begin
      dph_d = dir_wdata; // R12
    end
    // Direct write wins over a stack load
    sp_d = (wr_ok && sel_sp) ? dir_wdata : sp_load ? sp_value : sp_q; // R14
    // Bit 7 is stored as written; software is expected to keep it set
    cfg_d   = (wr_ok && sel_cfg) ? (dir_wdata & `MCSFR_CFG_MASK) : cfg_q; // R15
    ext_pin_config_reg_d = (wr_ok && sel_ext_pin_config_reg) ? dir_wdata : ext_pin_config_reg_q;
  end

  // Read mux; unmapped addresses read zero without a hit
  mcsfr_byte_t rd_mux;
  always_comb begin
    if (sel_acc) begin
      rd_mux = acc_q;
    end else if (sel_b) begin
      rd_mux = aux_q;
    end else if (sel_psw) begin
      rd_mux = psw_q;
    end else if (sel_program_control_reg) begin
      rd_mux = program_control_reg_q;
    end else if (sel_dpl) begin
      rd_mux = dpl_q;
    end else if (sel_dph) begin
      rd_mux = dph_q;
    end else if (sel_sp) begin
      rd_mux = sp_q;
    end else if (sel_cfg) begin
      rd_mux = cfg_q;
    end else if (sel_ext_pin_config_reg) begin
      rd_mux = ext_pin_config_reg_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  wire rd_ok = dir_rd && dir_ok && mapped; // R1
  // Read data drops to zero after one cycle so stale data never looks valid
  assign rdata_d = rd_ok ? rd_mux : 8'h00;
  assign hit_d   = (dir_rd || dir_wr) && dir_ok && mapped;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q   <= `MCSFR_RST_ACC;
      aux_q   <= `MCSFR_RST_B;
      psw_q   <= `MCSFR_RST_PSW;
      program_control_reg_q  <= `MCSFR_RST_PROGRAM_CONTROL_REG;
      dpl_q   <= `MCSFR_RST_DP;
      dph_q   <= `MCSFR_RST_DP;
      sp_q    <= `MCSFR_RST_SP;
      cfg_q   <= `MCSFR_RST_CFG;
      ext_pin_config_reg_q <= `MCSFR_RST_EXT_PIN_CONFIG_REG;
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      aux_q   <= aux_d;
      psw_q   <= psw_d;
      program_control_reg_q  <= program_control_reg_d;
      dpl_q   <= dpl_d;
      dph_q   <= dph_d;
      sp_q    <= sp_d;
      cfg_q   <= cfg_d;
      ext_pin_config_reg_q <= ext_pin_config_reg_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // Bank storage has no reset; contents are unknown until written
  // Bank RAM index: bank select above the register number
  wire mcsfr_bank_t cur_bank = psw_q[`MCSFR_PSW_RS1:`MCSFR_PSW_RS0]; // R8
  wire [4:0] bank_addr = {cur_bank, bank_reg}; // R9
  mcsfr_byte_t bank_rd;

  mcsfr_bank_ram #(
    .DEPTH (32),
    .AW    (5)
  ) u_bank_ram (
    .sys_clk (sys_clk),
    .wr_en   (bank_wr),
    .wr_addr (bank_addr),
    .wr_data (bank_wdata),
    .rd_addr (bank_addr),
    .rd_data (bank_rd)
  );

  // Output views, all registered
  // Bank select and extended-move views taken from next values so they do not lag; bank read data gets a second register stage
  mcsfr_bank_t bank_sel_q;
  logic        ext_q;
  mcsfr_byte_t bank_out_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bank_sel_q <= 2'h0;
      ext_q      <= 1'b0;
      bank_out_q <= 8'h00;
    end else begin
      bank_sel_q <= psw_d[`MCSFR_PSW_RS1:`MCSFR_PSW_RS0]; // R8
      ext_q      <= cfg_d[`MCSFR_CFG_XR1] | cfg_d[`MCSFR_CFG_XR0]; // R19
      bank_out_q <= bank_rd;
    end
  end

  assign dir_rdata          = rdata_q;
  assign dir_hit            = hit_q;
  assign bank_rdata         = bank_out_q;
  assign acc_out            = acc_q;
  assign aux_out            = aux_q;
  assign sp_out             = sp_q;
  assign pointer_pair_word_out           = {dph_q, dpl_q}; // R13
  assign bank_sel           = bank_sel_q;
  assign carry_flag         = psw_q[`MCSFR_PSW_CY];
  assign baud_doubler       = program_control_reg_q[`MCSFR_PROGRAM_CONTROL_REG_DBL]; // R10
  assign rich_serial_enable = cfg_q[`MCSFR_CFG_RICH]; // R16
  assign sync_port_choice   = cfg_q[`MCSFR_CFG_SYNC]; // R17
  assign carrier_enable     = cfg_q[`MCSFR_CFG_CARR]; // R18
  assign carrier_pin_mask   = ext_pin_config_reg_q; // R18
  assign ext_move_enable    = ext_q; // R19
endmodule
`default_nettype wire

// ===== inc/mcsfr_defines.svh
// Offsets, field positions and reset values of the core register set
`ifndef MCSFR_DEFINES_SVH
`define MCSFR_DEFINES_SVH
`define MCSFR_DIRECT_BASE   8'h80
`define MCSFR_BANK_BYTES    6'd32
`define MCSFR_OFF_SP        8'h81
`define MCSFR_OFF_DPL       8'h82
`define MCSFR_OFF_DPH       8'h83
`define MCSFR_OFF_PROGRAM_CONTROL_REG      8'h87
`define MCSFR_OFF_EXT_PIN_CONFIG_REG     8'h9f
`define MCSFR_OFF_CFG       8'haf
`define MCSFR_OFF_PSW       8'hd0
`define MCSFR_OFF_ACC       8'he0
`define MCSFR_OFF_B         8'hf0
`define MCSFR_RST_SP        8'h07
`define MCSFR_RST_DP        8'h00
`define MCSFR_RST_PROGRAM_CONTROL_REG      8'h00
`define MCSFR_RST_CFG       8'h80
`define MCSFR_RST_PSW       8'h00
`define MCSFR_RST_ACC       8'h00
`define MCSFR_RST_B         8'h00
`define MCSFR_RST_EXT_PIN_CONFIG_REG     8'h00
`define MCSFR_PROGRAM_CONTROL_REG_MASK     8'h80
`define MCSFR_CFG_MASK      8'hf3
`define MCSFR_PSW_CY        7
`define MCSFR_PSW_AC        6
`define MCSFR_PSW_F0        5
`define MCSFR_PSW_RS1       4
`define MCSFR_PSW_RS0       3
`define MCSFR_PSW_OV        2
`define MCSFR_PSW_F1        1
`define MCSFR_PSW_P         0
`define MCSFR_PROGRAM_CONTROL_REG_DBL      7
`define MCSFR_CFG_RICH      6
`define MCSFR_CFG_SYNC      5
`define MCSFR_CFG_CARR      4
`define MCSFR_CFG_XR1       1
`define MCSFR_CFG_XR0       0
`endif

// ===== inc/mcsfr_pkg.sv
// Types shared by the core register set
package mcsfr_pkg;
  typedef logic [7:0]  mcsfr_byte_t;
  typedef logic [15:0] mcsfr_word_t;
  typedef logic [1:0]  mcsfr_bank_t;
  typedef enum logic [3:0] {
    MCSFR_ALU_NONE = 4'h1,
    MCSFR_ALU_ADD  = 4'h2,
    MCSFR_ALU_SUB  = 4'h4,
    MCSFR_ALU_MD   = 4'h8
  } mcsfr_alu_t;
endpackage

// ===== verilog/mcsfr_bank_ram.sv
// Register bank storage: four banks of eight bytes, registered read
`timescale 1ns/1ps
`default_nettype none
module mcsfr_bank_ram #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== bench/mcsfr_core_regs_chk.sv
// Port checker for the core register set
`timescale 1ns/1ps
`default_nettype none
module mcsfr_core_regs_chk (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   dir_wr,
  input wire logic                   dir_rd,
  input wire logic                   dir_indirect,
  input wire logic [7:0]             dir_addr,
  input wire mcsfr_pkg::mcsfr_byte_t dir_wdata,
  input wire mcsfr_pkg::mcsfr_byte_t dir_rdata,
  input wire logic                   dir_hit,
  input wire mcsfr_pkg::mcsfr_alu_t  alu_kind,
  input wire logic                   alu_carry,
  input wire logic                   alu_half,
  input wire mcsfr_pkg::mcsfr_byte_t acc_out,
  input wire mcsfr_pkg::mcsfr_byte_t sp_out,
  input wire mcsfr_pkg::mcsfr_word_t pointer_pair_word_out,
  input wire mcsfr_pkg::mcsfr_bank_t bank_sel,
  input wire logic                   carry_flag,
  input wire logic                   baud_doubler
);
  import mcsfr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire             rd_ok = dir_rd && !dir_indirect && !dir_wr;
  wire             wr_ok = dir_wr && !dir_indirect;
  wire [7:0]       dp_lo = pointer_pair_word_out[7:0];
  wire [1:0]       wbank = dir_wdata[4:3];
  wire             wtop  = dir_wdata[7];
  sequence add_op; alu_kind == MCSFR_ALU_ADD && !dir_wr; endsequence
  sequence psw_rd; rd_ok && dir_addr == 8'hd0 && alu_kind == MCSFR_ALU_NONE; endsequence
  indir_refuse_a: assert property ((dir_rd || dir_wr) && dir_indirect |=>
    !dir_hit && dir_rdata == 8'h00) else $error("indirect access answered");
  low_refuse_a: assert property (dir_rd && dir_addr < 8'h80 |=>
    !dir_hit && dir_rdata == 8'h00) else $error("low address answered");
  sp_read_a: assert property (rd_ok && dir_addr == 8'h81 |=>
    dir_hit && dir_rdata == $past(sp_out)) else $error("stack read wrong");
  pointer_pair_word_low_a: assert property (rd_ok && dir_addr == 8'h82 |=>
    dir_rdata == $past(dp_lo)) else $error("pointer low read wrong");
  parity_even_a: assert property (psw_rd |=> dir_rdata[0] == ^$past(acc_out))
    else $error("parity bit wrong");
  carry_upd_a: assert property (alu_kind != MCSFR_ALU_NONE |=>
    carry_flag == $past(alu_carry)) else $error("carry not updated");
  half_add_a: assert property (add_op ##1 psw_rd |=>
    dir_rdata[6] == $past(alu_half, 2)) else $error("half carry wrong");
  bank_sel_a: assert property (wr_ok && dir_addr == 8'hd0 |=>
    bank_sel == $past(wbank)) else $error("bank select wrong");
  baud_wr_a: assert property (wr_ok && dir_addr == 8'h87 |=>
    baud_doubler == $past(wtop)) else $error("baud bit wrong");
endmodule
bind mcsfr_core_regs mcsfr_core_regs_chk chk (
  .sys_clk      (sys_clk),
  .rst          (rst),
  .dir_wr       (dir_wr),
  .dir_rd       (dir_rd),
  .dir_indirect (dir_indirect),
  .dir_addr     (dir_addr),
  .dir_wdata    (dir_wdata),
  .dir_rdata    (dir_rdata),
  .dir_hit      (dir_hit),
  .alu_kind     (alu_kind),
  .alu_carry    (alu_carry),
  .alu_half     (alu_half),
  .acc_out      (acc_out),
  .sp_out       (sp_out),
  .pointer_pair_word_out     (pointer_pair_word_out),
  .bank_sel     (bank_sel),
  .carry_flag   (carry_flag),
  .baud_doubler (baud_doubler)
);
`default_nettype wire

// ===== bench/mcsfr_core_regs_bench.sv
// Self-checking bench of the core register set
`timescale 1ns/1ps
`default_nettype none
module mcsfr_core_regs_bench;
  import mcsfr_pkg::*;
  logic        sys_clk, rst, dir_wr, dir_rd, dir_indirect, dir_hit, bank_wr;
  logic        alu_carry, alu_half, alu_ovf, acc_load, sp_load, pointer_pair_word_load;
  logic        carry_flag, baud_doubler, rich_serial_enable, sync_port_choice;
  logic        carrier_enable, ext_move_enable;
  logic [7:0]  dir_addr;
  logic [2:0]  bank_reg;
  mcsfr_byte_t dir_wdata, dir_rdata, bank_wdata, bank_rdata, acc_value, sp_value;
  mcsfr_byte_t acc_out, aux_out, sp_out, carrier_pin_mask;
  mcsfr_word_t pointer_pair_word_value, pointer_pair_word_out;
  mcsfr_bank_t bank_sel;
  mcsfr_alu_t  alu_kind;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  mcsfr_core_regs DUT (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .dir_wr             (dir_wr),
    .dir_rd             (dir_rd),
    .dir_addr           (dir_addr),
    .dir_wdata          (dir_wdata),
    .dir_rdata          (dir_rdata),
    .dir_hit            (dir_hit),
    .dir_indirect       (dir_indirect),
    .bank_wr            (bank_wr),
    .bank_reg           (bank_reg),
    .bank_wdata         (bank_wdata),
    .bank_rdata         (bank_rdata),
    .alu_kind           (alu_kind),
    .alu_carry          (alu_carry),
    .alu_half           (alu_half),
    .alu_ovf            (alu_ovf),
    .acc_load           (acc_load),
    .acc_value          (acc_value),
    .sp_load            (sp_load),
    .sp_value           (sp_value),
    .pointer_pair_word_load          (pointer_pair_word_load),
    .pointer_pair_word_value         (pointer_pair_word_value),
    .acc_out            (acc_out),
    .aux_out            (aux_out),
    .sp_out             (sp_out),
    .pointer_pair_word_out           (pointer_pair_word_out),
    .bank_sel           (bank_sel),
    .carry_flag         (carry_flag),
    .baud_doubler       (baud_doubler),
    .rich_serial_enable (rich_serial_enable),
    .sync_port_choice   (sync_port_choice),
    .carrier_enable     (carrier_enable),
    .carrier_pin_mask   (carrier_pin_mask),
    .ext_move_enable    (ext_move_enable)
  );
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, mcsfr_byte_t d);
    @(negedge sys_clk);
    alu_kind = MCSFR_ALU_NONE;
    {dir_wr, dir_addr, dir_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    dir_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, mcsfr_byte_t e, logic h);
    @(negedge sys_clk);
    alu_kind = MCSFR_ALU_NONE;
    {dir_rd, dir_addr} = {1'b1, a};
    @(negedge sys_clk);
    dir_rd = 0;
    cmp("dir_rdata", e, dir_rdata);
    cmp("dir_hit", h, dir_hit);
  endtask
  // Leaves the operation up; the next access ends it
  task automatic alu(mcsfr_alu_t k, logic [2:0] cho);
    @(negedge sys_clk);
    alu_kind = k;
    {alu_carry, alu_half, alu_ovf} = cho;
  endtask
  task automatic bw(mcsfr_byte_t d);
    @(negedge sys_clk);
    {bank_wr, bank_wdata} = {1'b1, d};
    @(negedge sys_clk);
    bank_wr = 0;
  endtask
  task automatic t_reset;
    cmp("sp_out", 8'h07, sp_out);
    cmp("pointer_pair_word_out", 16'h0000, pointer_pair_word_out);
    cmp("baud_doubler", 1'b0, baud_doubler);
    cmp("ext_move_enable", 1'b0, ext_move_enable);
    rd(8'h87, 8'h00, 1);
    rd(8'hd0, 8'h00, 1);
  endtask
  task automatic t_ptr;
    wr(8'h81, 8'h55);
    rd(8'h81, 8'h55, 1);
    wr(8'h82, 8'h12);
    wr(8'h83, 8'h34);
    cmp("pointer_pair_word_out", 16'h3412, pointer_pair_word_out);
    @(negedge sys_clk);
    {pointer_pair_word_load, pointer_pair_word_value} = {1'b1, 16'habcd};
    @(negedge sys_clk);
    pointer_pair_word_load = 0;
    rd(8'h83, 8'hab, 1);
    rd(8'h82, 8'hcd, 1);
    wr(8'hf0, 8'h3c);
    cmp("aux_out", 8'h3c, aux_out);
    wr(8'h87, 8'hff);
    rd(8'h87, 8'h80, 1);
  endtask
  task automatic t_refuse;
    dir_indirect = 1;
    wr(8'h81, 8'h99);
    rd(8'h81, 8'h00, 0);
    dir_indirect = 0;
    cmp("sp_out", 8'h55, sp_out);
    rd(8'h7f, 8'h00, 0);
    rd(8'h80, 8'h00, 0);
  endtask
  task automatic t_psw;
    wr(8'hd0, 8'h18);
    cmp("bank_sel", 2'h3, bank_sel);
    wr(8'hd0, 8'h22);
    alu(MCSFR_ALU_SUB, 3'b111);
    rd(8'hd0, 8'ha6, 1);
    alu(MCSFR_ALU_ADD, 3'b010);
    rd(8'hd0, 8'h62, 1);
    alu(MCSFR_ALU_MD, 3'b101);
    rd(8'hd0, 8'he6, 1);
    cmp("carry_flag", 1'b1, carry_flag);
  endtask
  task automatic t_par;
    @(negedge sys_clk);
    {acc_load, acc_value} = {1'b1, 8'h07};
    @(negedge sys_clk);
    acc_load = 0;
    rd(8'hd0, 8'he7, 1);
    wr(8'he0, 8'h03);
    wr(8'hd0, 8'h01);
    rd(8'hd0, 8'h00, 1);
  endtask
  // Stack load, then a direct write racing a load
  task automatic t_load;
    @(negedge sys_clk);
    {sp_load, sp_value} = {1'b1, 8'h30};
    @(negedge sys_clk);
    cmp("sp_out", 8'h30, sp_out);
    {dir_wr, dir_addr, dir_wdata, sp_value} = {1'b1, 8'h81, 8'h44, 8'h31};
    @(negedge sys_clk);
    {dir_wr, sp_load} = 2'b00;
    cmp("sp_out", 8'h44, sp_out);
    cmp("acc_out", 8'h03, acc_out);
  endtask
  // Second reset in mid-run after every register has moved
  task automatic t_rerst;
    @(negedge sys_clk);
    rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    cmp("sp_out", 8'h07, sp_out);
    cmp("pointer_pair_word_out", 16'h0000, pointer_pair_word_out);
    cmp("baud_doubler", 1'b0, baud_doubler);
    cmp("bank_sel", 2'h0, bank_sel);
    cmp("ext_move_enable", 1'b0, ext_move_enable);
    cmp("dir_hit", 1'b0, dir_hit);
    rd(8'haf, 8'h80, 1);
    rd(8'hd0, 8'h00, 1);
  endtask
  task automatic t_bank;
    wr(8'hd0, 8'h08);
    bw(8'h11);
    wr(8'hd0, 8'h10);
    bw(8'h22);
    wr(8'hd0, 8'h08);
    repeat (2) @(negedge sys_clk);
    cmp("bank_rdata", 8'h11, bank_rdata);
    wr(8'hd0, 8'h10);
    bank_reg = 3'h5;
    bw(8'h5a);
    bank_reg = 3'h3;
    repeat (2) @(negedge sys_clk);
    cmp("bank_rdata", 8'h22, bank_rdata);
    bank_reg = 3'h5;
    repeat (2) @(negedge sys_clk);
    cmp("bank_rdata", 8'h5a, bank_rdata);
  endtask
  task automatic t_cfg;
    logic [7:0] cv [4] = '{8'hf3, 8'h8c, 8'hc1, 8'hb2};
    logic [3:0] outs;
    wr(8'h9f, 8'h5a);
    cmp("carrier_pin_mask", 8'h5a, carrier_pin_mask);
    for (int i = 0; i < 4; i++) begin
      wr(8'haf, cv[i]);
      rd(8'haf, cv[i] & 8'hf3, 1);
      outs = {rich_serial_enable, sync_port_choice, carrier_enable, ext_move_enable};
      cmp("cfg_outs", {cv[i][6:4], |cv[i][1:0]}, outs);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {rst, dir_wr, dir_rd, dir_indirect, bank_wr, acc_load, sp_load, pointer_pair_word_load} = 8'h80;
    {alu_carry, alu_half, alu_ovf, bank_reg} = 6'h03;
    {dir_addr, dir_wdata, bank_wdata, acc_value, sp_value, pointer_pair_word_value} = 56'h0;
    alu_kind = MCSFR_ALU_NONE;
    repeat (5) @(negedge sys_clk);
    rst = 0;
    t_reset();
    t_ptr();
    t_refuse();
    t_psw();
    t_par();
    t_load();
    t_bank();
    t_cfg();
    t_rerst();
    summarize();
  end
endmodule
`default_nettype wire
